// ---- rtl/cmx_top.sv ----
// comparator status, select, input disable and interrupt logic with AHB-Lite registers
//
// Notes on behaviour
// - comparator negative select: six sources, two reserved
// - halve bit divides comparator clock by two
// - comparator 2 flag set on sensed edge
// - comparator 1 flag set on sensed edge
// - comparator 0 flag set on sensed edge
// - flag cleared when enabled interrupt is taken
// - writing one clears flag, zero keeps
// - flags offered as conversion triggers
// - status low bits read live comparator levels
// - first disable register: negative and comparator-2 pins
// - second disable register: comparator 0, 1 pins
// - disabled pin always reads zero
// - sense: toggle, reserved, falling, rising
// - sample on each comparator clock falling edge; the block samples on the rising clock edge of each cmp_sample tick
// - output high when positive exceeds negative
// - per comparator interrupt enable gates request
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`include "cmx_defs.svh"

module cmx_top
  import cmx_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // comparator cores
  input  wire logic [2:0]  cmp_raw,
  output logic [2:0]       cmp_enable,
  output logic             cmp_sample,
  output logic [5:0]       cmp_neg_route0,
  output logic [5:0]       cmp_neg_route1,
  output logic [5:0]       cmp_neg_route2,
  // analog pins: 0 negative, 1 cmp2 positive, 2 cmp0 positive, 3 cmp1 positive
  input  wire logic [3:0]  pin_in,
  output logic [3:0]       pin_read,
  output logic [3:0]       pin_buffer_off,
  // events and interrupts
  input  wire logic [2:0]  irq_taken,
  output logic [2:0]       cmp_irq_req,
  output logic [2:0]       cmp_trigger,
  output logic             irq
);

  // ***************************************************************
  // state
  // ***************************************************************
  cmx_ctrl_t  ctrl [3];
  logic       cmp_clock_halve;
  logic       phase;
  logic [7:0] buffer_off_first;
  logic [7:0] buffer_off_second;
  logic [7:0] irq_mask;
  logic [3:0] pin_sync1;
  logic [3:0] pin_sync2;
  logic [2:0] level;
  logic [2:0] flag;
  logic [2:0] evt;
  logic [2:0] clr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  cmx_wr_t    wr;
  logic [7:0] status;

  // ***************************************************************
  // bus front end
  // ***************************************************************
  cmx_ahb_slave u_bus (
    .clock     (clock),
    .nrst      (nrst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr        (wr)
  );

  // ***************************************************************
  // decode
  // ***************************************************************
  wire       wr_ctrl0   = wr.valid && wr.addr == `CMX_OFS_CTRL0;
  wire       wr_ctrl1   = wr.valid && wr.addr == `CMX_OFS_CTRL1;
  wire       wr_ctrl2   = wr.valid && wr.addr == `CMX_OFS_CTRL2;
  wire       wr_status  = wr.valid && wr.addr == `CMX_OFS_STATUS;
  wire       wr_bufoff0 = wr.valid && wr.addr == `CMX_OFS_BUFOFF0;
  wire       wr_bufoff1 = wr.valid && wr.addr == `CMX_OFS_BUFOFF1;
  wire       wr_irqmask = wr.valid && wr.addr == `CMX_OFS_IRQMASK;
  wire [7:0] wbyte      = wr.data[7:0];
  wire [2:0] w1c_flags  = wr_status ? {wbyte[`CMX_ST_FLAG2], wbyte[`CMX_ST_FLAG1],
                                       wbyte[`CMX_ST_FLAG0]} : 3'h0;

  // ***************************************************************
  // comparator clock
  // ***************************************************************
  // one sample per system clock, or one every second clock when halved
  assign cmp_sample = ~cmp_clock_halve | phase;

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl[0] <= `CMX_RST_CTRL;
      ctrl[1] <= `CMX_RST_CTRL;
      ctrl[2] <= `CMX_RST_CTRL;
    end else begin
      if (wr_ctrl0) ctrl[0] <= {wbyte[7:4], 1'b0, wbyte[2:0]};
      if (wr_ctrl1) ctrl[1] <= {wbyte[7:4], 1'b0, wbyte[2:0]};
      if (wr_ctrl2) ctrl[2] <= {wbyte[7:4], 1'b0, wbyte[2:0]};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmp_clock_halve   <= 1'b0;
      phase             <= 1'b0;
      buffer_off_first  <= `CMX_RST_BYTE;
      buffer_off_second <= `CMX_RST_BYTE;
      irq_mask          <= `CMX_RST_BYTE;
    end else begin
      phase <= ~phase;
      if (wr_status) cmp_clock_halve <= wbyte[`CMX_ST_HALVE];
      if (wr_bufoff0) buffer_off_first <= wbyte;
      if (wr_bufoff1) buffer_off_second <= wbyte;
      if (wr_irqmask) irq_mask <= wbyte;
    end
  end

  // ***************************************************************
  // channels
  // ***************************************************************
  // flags clear by a written one or by a taken, enabled vector
  assign clr[0] = w1c_flags[0] | (irq_taken[0] & ctrl[0].ie);
  assign clr[1] = w1c_flags[1] | (irq_taken[1] & ctrl[1].ie);
  assign clr[2] = w1c_flags[2] | (irq_taken[2] & ctrl[2].ie);

  // comparator 0 event flag
  cmx_chan u_chan0 (
    .clock     (clock),
    .nrst      (nrst),
    .raw       (cmp_raw[0]),
    .sample    (cmp_sample),
    .ctrl      (ctrl[0]),
    .clr       (clr[0]),
    .level     (level[0]),
    .flag      (flag[0]),
    .evt       (evt[0]),
    .neg_route (cmp_neg_route0)
  );

  // comparator 1 event flag
  cmx_chan u_chan1 (
    .clock     (clock),
    .nrst      (nrst),
    .raw       (cmp_raw[1]),
    .sample    (cmp_sample),
    .ctrl      (ctrl[1]),
    .clr       (clr[1]),
    .level     (level[1]),
    .flag      (flag[1]),
    .evt       (evt[1]),
    .neg_route (cmp_neg_route1)
  );

  // comparator 2 event flag
  cmx_chan u_chan2 (
    .clock     (clock),
    .nrst      (nrst),
    .raw       (cmp_raw[2]),
    .sample    (cmp_sample),
    .ctrl      (ctrl[2]),
    .clr       (clr[2]),
    .level     (level[2]),
    .flag      (flag[2]),
    .evt       (evt[2]),
    .neg_route (cmp_neg_route2)
  );

  assign cmp_enable = {ctrl[2].en, ctrl[1].en, ctrl[0].en};

  // ***************************************************************
  // events and interrupts
  // ***************************************************************
  assign cmp_trigger = flag;
  assign cmp_irq_req = flag & {ctrl[2].ie, ctrl[1].ie, ctrl[0].ie};
  assign irq         = |(status & irq_mask & 8'h70);

  // ***************************************************************
  // input buffers
  // ***************************************************************
  assign pin_buffer_off = {buffer_off_second[`CMX_BO1_CMP1], buffer_off_second[`CMX_BO1_CMP0],
                           buffer_off_first[`CMX_BO0_CMP2],
                           buffer_off_first[`CMX_BO0_NEGPIN]};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_sync1 <= 4'h0;
      pin_sync2 <= 4'h0;
    end else begin
      pin_sync1 <= pin_in;
      pin_sync2 <= pin_sync1;
    end
  end

  assign pin_read = pin_sync2 & ~pin_buffer_off;

  // ***************************************************************
  // read back
  // ***************************************************************
  assign status  = {cmp_clock_halve, flag, 1'b0, level};
  assign rd_data = (rd_addr == `CMX_OFS_CTRL0)   ? ctrl[0] :
                   (rd_addr == `CMX_OFS_CTRL1)   ? ctrl[1] :
                   (rd_addr == `CMX_OFS_CTRL2)   ? ctrl[2] :
                   (rd_addr == `CMX_OFS_STATUS)  ? status :
                   (rd_addr == `CMX_OFS_BUFOFF0) ? buffer_off_first :
                   (rd_addr == `CMX_OFS_BUFOFF1) ? buffer_off_second :
                   (rd_addr == `CMX_OFS_IRQMASK) ? irq_mask : 8'h00;

  // ***************************************************************
  // checks
  // ***************************************************************
  sequence s_status_wr;
    hsel && hready && htrans == `CMX_HTRANS_NSEQ && hwrite && hsize == `CMX_HSIZE_WORD
      && haddr[7:0] == `CMX_OFS_STATUS;
  endsequence

  sequence s_status_rd;
    hsel && hready && htrans == `CMX_HTRANS_NSEQ && !hwrite
      && haddr[7:0] == `CMX_OFS_STATUS;
  endsequence

  a_halved_rate: assert property (@(posedge clock) disable iff (!nrst)
    cmp_clock_halve && $stable(cmp_clock_halve) && cmp_sample && !wr_status |=> !cmp_sample)
    else $error("halved comparator clock ticked twice");
  a_full_rate: assert property (@(posedge clock) disable iff (!nrst)
    !cmp_clock_halve |-> cmp_sample)
    else $error("full rate comparator clock missed a tick");
  a_w1c_flag2: assert property (@(posedge clock) disable iff (!nrst)
    s_status_wr ##1 (hwdata[`CMX_ST_FLAG2] && !evt[2]) |=> !flag[2])
    else $error("written one did not clear flag 2");
  a_w0_keeps: assert property (@(posedge clock) disable iff (!nrst)
    s_status_wr ##1 (!hwdata[`CMX_ST_FLAG1] && flag[1] && !irq_taken[1]) |=> flag[1])
    else $error("written zero cleared flag 1");
  a_taken_clears: assert property (@(posedge clock) disable iff (!nrst)
    irq_taken[0] && ctrl[0].ie && !evt[0] |=> !flag[0])
    else $error("taken vector left flag 0 set");
  a_taken_masked: assert property (@(posedge clock) disable iff (!nrst)
    irq_taken[0] && !ctrl[0].ie && flag[0] && !wr_status |=> flag[0])
    else $error("disabled vector cleared flag 0");
  a_read_levels: assert property (@(posedge clock) disable iff (!nrst)
    s_status_rd |=> hrdata[2:0] == $past(level))
    else $error("status read lost comparator levels");
  a_pin_zero: assert property (@(posedge clock) disable iff (!nrst)
    $past(buffer_off_first[`CMX_BO0_NEGPIN]) && $stable(buffer_off_first) |-> !pin_read[0])
    else $error("disabled pin read as one");
  a_req_gated: assert property (@(posedge clock) disable iff (!nrst)
    !ctrl[2].ie |-> !cmp_irq_req[2])
    else $error("request without enable");
  a_req_follows: assert property (@(posedge clock) disable iff (!nrst)
    evt[1] && ctrl[1].ie && $stable(ctrl[1]) && !wr_ctrl1 |=> cmp_irq_req[1])
    else $error("request missing after event");

  // ***************************************************************
  // checks: status write, read back, disabled level, trigger, interrupt and pins
  // ***************************************************************
  a_halve_write: assert property (@(posedge clock) disable iff (!nrst)
    s_status_wr ##1 1'b1 |=> cmp_clock_halve == $past(hwdata[`CMX_ST_HALVE]))
    else $error("halve bit not taken from status write");
  a_read_halve: assert property (@(posedge clock) disable iff (!nrst)
    s_status_rd |=> hrdata[`CMX_ST_HALVE] == $past(cmp_clock_halve))
    else $error("status read lost halve bit");
  a_read_flags: assert property (@(posedge clock) disable iff (!nrst)
    s_status_rd |=> hrdata[`CMX_ST_FLAG2:`CMX_ST_FLAG0] == $past(flag))
    else $error("status read lost event flags");
  a_disabled_level: assert property (@(posedge clock) disable iff (!nrst)
    !ctrl[1].en |=> !level[1])
    else $error("disabled comparator showed a high level");
  a_trigger_follows: assert property (@(posedge clock) disable iff (!nrst)
    evt[2] |=> cmp_trigger[2])
    else $error("event did not raise conversion trigger");
  a_irq_unmasked: assert property (@(posedge clock) disable iff (!nrst)
    flag[0] && irq_mask[`CMX_ST_FLAG0] |-> irq)
    else $error("unmasked flag raised no interrupt");
  a_pin_cmp0_off: assert property (@(posedge clock) disable iff (!nrst)
    buffer_off_second[`CMX_BO1_CMP0] |-> !pin_read[2])
    else $error("disabled comparator 0 pin read as one");
endmodule // cmx_top

// ---- shared/cmx_defs.svh ----
// register offsets, bit positions, reset values and codes of the comparator control block
`ifndef CMX_DEFS_SVH
`define CMX_DEFS_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define CMX_OFS_CTRL0    8'h00
`define CMX_OFS_CTRL1    8'h04
`define CMX_OFS_CTRL2    8'h08
`define CMX_OFS_STATUS   8'h0C
`define CMX_OFS_BUFOFF0  8'h10
`define CMX_OFS_BUFOFF1  8'h14
`define CMX_OFS_IRQMASK  8'h18

// ***************************************************************
// shared status fields
// ***************************************************************
`define CMX_ST_HALVE     7
`define CMX_ST_FLAG2     6
`define CMX_ST_FLAG1     5
`define CMX_ST_FLAG0     4
`define CMX_ST_LEVEL2    2
`define CMX_ST_LEVEL1    1
`define CMX_ST_LEVEL0    0

// ***************************************************************
// input buffer disable fields
// ***************************************************************
`define CMX_BO0_NEGPIN   3
`define CMX_BO0_CMP2     2
`define CMX_BO1_CMP0     5
`define CMX_BO1_CMP1     2

// ***************************************************************
// reset values
// ***************************************************************
`define CMX_RST_CTRL     8'h00
`define CMX_RST_BYTE     8'h00

// ***************************************************************
// sense, negative input and bus transfer codes
// ***************************************************************
`define CMX_SENSE_TOGGLE 2'h0
`define CMX_SENSE_FALL   2'h2
`define CMX_SENSE_RISE   2'h3
`define CMX_NEG_LAST     3'h5
`define CMX_HSIZE_WORD   3'h2
`define CMX_HTRANS_NSEQ  2'h2

`endif

// ---- shared/cmx_pkg.sv ----
// types shared by the comparator control block
package cmx_pkg;

  // one comparator control byte
  typedef struct packed {
    logic       en;
    logic       ie;
    logic [1:0] sense;
    logic       spare;
    logic [2:0] neg_sel;
  } cmx_ctrl_t;

  // register write taken from the bus
  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } cmx_wr_t;

endpackage

// ---- rtl/cmx_ahb_slave.sv ----
// AHB-Lite slave front end of the comparator control block
`include "cmx_defs.svh"

module cmx_ahb_slave
  import cmx_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // AHB-Lite
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // register side
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data,
  output cmx_wr_t          wr
);
  logic       wr_pend;
  logic [7:0] wr_addr;

  wire take    = hsel & hready & (htrans == `CMX_HTRANS_NSEQ);
  wire take_wr = take & hwrite & (hsize == `CMX_HSIZE_WORD);
  wire take_rd = take & ~hwrite;

  // zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_addr   = haddr[7:0];
  assign wr        = '{valid: wr_pend, addr: wr_addr, data: hwdata};

  // read data is fetched in the address phase and stands in the data phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_pend <= take_wr;
      wr_addr <= haddr[7:0];
      hrdata  <= take_rd ? {24'h00_0000, rd_data} : 32'h0000_0000;
    end
  end
endmodule // cmx_ahb_slave

// ---- rtl/cmx_chan.sv ----
// one comparator channel: result sampling, edge sensing and event flag
`include "cmx_defs.svh"

module cmx_chan
  import cmx_pkg::*;
(
  // clock and reset
  input  wire logic      clock,
  input  wire logic      nrst,
  // comparator core
  input  wire logic      raw,
  input  wire logic      sample,
  // control
  input  wire cmx_ctrl_t ctrl,
  input  wire logic      clr,
  // results
  output logic           level,
  output logic           flag,
  output logic           evt,
  output logic [5:0]     neg_route
);
  logic sync1;
  logic sync2;

  // result moves only on a comparator clock tick while enabled, and drops to zero when disabled
  wire next_level = ctrl.en ? (sample ? sync2 : level) : 1'b0;
  wire rise       = ~level & next_level;
  wire fall       = level & ~next_level;
  wire sense_hit  = (ctrl.sense == `CMX_SENSE_TOGGLE) ? (rise | fall) :
                    (ctrl.sense == `CMX_SENSE_FALL)   ? fall :
                    (ctrl.sense == `CMX_SENSE_RISE)   ? rise : 1'b0;
  assign evt      = ctrl.en & sample & sense_hit;
  // a set in the clearing cycle wins
  wire next_flag  = evt | (flag & ~clr);
  // reserved codes close no switch
  wire [5:0] next_route = (ctrl.neg_sel <= `CMX_NEG_LAST) ?
                          (6'h01 << ctrl.neg_sel) : 6'h00;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      level     <= 1'b0;
      flag      <= 1'b0;
      neg_route <= 6'h00;
    end else begin
      sync1     <= raw;
      sync2     <= sync1;
      level     <= next_level;
      flag      <= next_flag;
      neg_route <= next_route;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_steady_input;
    (ctrl.en && $stable(raw) && $stable(ctrl.en))[*6];
  endsequence

  a_rise_sets_flag: assert property (
    $rose(level) && $past(ctrl.sense) == `CMX_SENSE_RISE |-> flag)
    else $error("rising edge did not set flag");
  a_fall_sets_flag: assert property (
    $fell(level) && $past(ctrl.en) && $past(ctrl.sense) == `CMX_SENSE_FALL |-> flag)
    else $error("falling edge did not set flag");
  a_reserved_sense: assert property (
    $past(ctrl.sense) == 2'h1 && !$past(flag) |-> !flag)
    else $error("reserved sense code set flag");
  a_clear_drops_flag: assert property (
    clr && !evt |=> !flag)
    else $error("flag survived its clear");
  a_set_beats_clear: assert property (
    clr && evt |=> flag)
    else $error("set lost against clear");
  a_level_tracks: assert property (
    s_steady_input |-> level == raw)
    else $error("level did not follow comparator");
  a_route_reserved: assert property (
    ctrl.neg_sel > `CMX_NEG_LAST |=> neg_route == 6'h00)
    else $error("reserved code drove a route");
endmodule // cmx_chan

// ---- verification/cmx_cmp_model.sv ----
// behavioural analog comparator cores with their negative-input sources
module cmx_cmp_model #(
  parameter int REF_MV = 2560
) (
  // clock
  input  wire logic             clock,
  // analog levels in millivolts
  input  wire logic [2:0][15:0] pos_mv,
  input  wire logic [15:0]      ext_mv,
  input  wire logic [15:0]      dac_mv,
  // control from the block
  input  wire logic [2:0]       cmp_enable,
  input  wire logic [2:0][5:0]  route,
  // results
  output logic [2:0]            cmp_raw
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0][15:0] neg_mv;
  logic             idle_pat = 1'b0;

  // a disabled core gives no meaningful result: show a changing pattern
  always @(posedge clock) idle_pat <= ~idle_pat;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (route[i][0]) neg_mv[i] = 16'(REF_MV * 100 / 640);
      else if (route[i][1]) neg_mv[i] = 16'(REF_MV * 100 / 320);
      else if (route[i][2]) neg_mv[i] = 16'(REF_MV * 100 / 213);
      else if (route[i][3]) neg_mv[i] = 16'(REF_MV * 100 / 160);
      else if (route[i][4]) neg_mv[i] = ext_mv;
      else if (route[i][5]) neg_mv[i] = dac_mv;
      else neg_mv[i] = 16'hFFFF;
      cmp_raw[i] = cmp_enable[i] ? (pos_mv[i] > neg_mv[i]) : idle_pat;
    end
  end
endmodule // cmx_cmp_model

// ---- verification/cmx_top_tb.sv ----
// self-checking testbench of the comparator control block
`include "cmx_defs.svh"

module cmx_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [7:0]  exp;
  } cmx_row_t;

  logic             clock, nrst, hsel, hwrite, hreadyout, hresp, cmp_sample, irq;
  logic [31:0]      haddr, hwdata, hrdata, hrdata_q;
  logic [1:0]       htrans;
  logic [2:0]       hsize, cmp_enable, cmp_irq_req, cmp_trigger, irq_taken, ticks;
  logic [5:0]       route0, route1, route2;
  logic [3:0]       pin_in, pin_read, pin_buffer_off;
  logic [2:0][15:0] pos_mv;
  logic [15:0]      ext_mv, dac_mv;
  logic [2:0]       cmp_raw;
  int               n_errors, n_compared;

  cmx_row_t rows [8] = '{
    '{`CMX_OFS_CTRL0, 32'h0000_00FF, 8'hF7}, '{`CMX_OFS_CTRL1, 32'h0000_0045, 8'h45},
    '{`CMX_OFS_CTRL2, 32'hFFFF_FFA3, 8'hA3}, '{`CMX_OFS_BUFOFF0, 32'h0000_00FF, 8'hFF},
    '{`CMX_OFS_BUFOFF1, 32'h0000_005A, 8'h5A}, '{`CMX_OFS_IRQMASK, 32'h0000_0070, 8'h70},
    '{8'h1C, 32'h0000_00FF, 8'h00}, '{8'h40, 32'h0000_00FF, 8'h00}};

  cmx_top u_cmx_top (
    .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cmp_raw(cmp_raw), .cmp_enable(cmp_enable), .cmp_sample(cmp_sample),
    .cmp_neg_route0(route0), .cmp_neg_route1(route1), .cmp_neg_route2(route2),
    .pin_in(pin_in), .pin_read(pin_read), .pin_buffer_off(pin_buffer_off),
    .irq_taken(irq_taken), .cmp_irq_req(cmp_irq_req), .cmp_trigger(cmp_trigger), .irq(irq));

  cmx_cmp_model u_cmx_cmp_model (
    .clock(clock), .pos_mv(pos_mv), .ext_mv(ext_mv), .dac_mv(dac_mv),
    .cmp_enable(cmp_enable), .route({route2, route1, route0}), .cmp_raw(cmp_raw));

  // ********
  // clock, bus capture, watchdog
  // ********
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // read data is taken at the edge that ends the data phase
  always @(posedge clock) hrdata_q <= hrdata;

  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    finish_test();
  end

  // ********
  // tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= `CMX_HTRANS_NSEQ;
    hwrite <= wr;
    hsize  <= `CMX_HSIZE_WORD;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    #1 r = hrdata_q;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(what, r & m, exp);
  endtask

  task automatic settle();
    repeat (6) @(posedge clock);
    #1;
  endtask

  task automatic drive_pos(input int ch, input logic [15:0] v);
    @(posedge clock);
    pos_mv[ch] <= v;
    settle();
  endtask

  task automatic count_samples(input logic [2:0] exp);
    ticks = 3'h0;
    repeat (4) begin
      @(posedge clock);
      #1 ticks = ticks + {2'h0, cmp_sample};
    end
    check("sample ticks", {29'h0, ticks}, {29'h0, exp});
  endtask

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h0; hwdata = 32'h0; irq_taken = 3'h0; pin_in = 4'hF;
    pos_mv = '0; ext_mv = 16'h0; dac_mv = 16'h0; n_errors = 0; n_compared = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    #1 check("reset outputs", {19'h0, hresp, irq, cmp_sample, pin_read, route0},
             32'h400);
    for (int a = 0; a < 28; a += 4) rdchk("reset value", 8'(a), 32'hFF, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdchk("register", rows[i].addr, 32'hFFFF_FFFF, {24'h0, rows[i].exp});
    end
    settle();
    check("buffer off", {28'h0, pin_buffer_off}, 32'h3);
    check("pin read", {28'h0, pin_read}, 32'hC);
    check("row routes", {14'h0, route2, route1, route0}, 32'h8800);
    check("enables", {29'h0, cmp_enable}, 32'h5);
    wr(`CMX_OFS_BUFOFF0, 32'h0);
    wr(`CMX_OFS_BUFOFF1, 32'h24);
    settle();
    check("pin read", {24'h0, pin_buffer_off, pin_read}, 32'hC3);
    for (int c = 0; c < 8; c++) begin
      wr(`CMX_OFS_CTRL2, 32'h80 | c);
      settle();
      check("neg route", {26'h0, route2}, (c < 6) ? (32'h1 << c) : 32'h0);
    end
    pos_mv[2] <= 16'h03E8;
    for (int c = 4; c < 6; c++) begin
      for (int v = 0; v < 2; v++) begin
        wr(`CMX_OFS_CTRL2, 32'h80 | c);
        ext_mv <= ((c == 4) == (v == 1)) ? 16'h01F4 : 16'h07D0;
        dac_mv <= ((c == 4) == (v == 1)) ? 16'h07D0 : 16'h01F4;
        settle();
        rdchk("source level", `CMX_OFS_STATUS, 32'h4, 32'(v) << 2);
      end
    end
    for (int ch = 0; ch < 3; ch++) begin
      for (int s = 0; s < 4; s++) begin
        drive_pos(ch, 16'h0);
        wr(8'(ch * 4), 32'hC0 | (s << 4));
        settle();
        wr(`CMX_OFS_STATUS, 32'h70);
        drive_pos(ch, 16'h03E8);
        rdchk("rise event", `CMX_OFS_STATUS, 32'h11 << ch,
              ((s == 0 || s == 3) ? 32'h10 << ch : 32'h0) | (32'h1 << ch));
        wr(`CMX_OFS_STATUS, 32'h70);
        drive_pos(ch, 16'h0);
        rdchk("fall event", `CMX_OFS_STATUS, 32'h11 << ch,
              (s == 0 || s == 2) ? 32'h10 << ch : 32'h0);
      end
    end
    wr(`CMX_OFS_CTRL0, 32'hF0);
    wr(`CMX_OFS_IRQMASK, 32'h10);
    wr(`CMX_OFS_STATUS, 32'h70);
    drive_pos(0, 16'h03E8);
    check("irq outputs", {cmp_irq_req, cmp_trigger, irq}, 32'h13);
    wr(`CMX_OFS_IRQMASK, 32'h0);
    #1 check("irq masked", {cmp_irq_req, irq}, 32'h2);
    wr(`CMX_OFS_CTRL0, 32'hB0);
    @(posedge clock);
    irq_taken <= 3'h1;
    @(posedge clock);
    irq_taken <= 3'h0;
    #1 check("taken ie off", {cmp_irq_req, cmp_trigger}, 32'h1);
    wr(`CMX_OFS_CTRL0, 32'hF0);
    @(posedge clock);
    irq_taken <= 3'h1;
    @(posedge clock);
    irq_taken <= 3'h0;
    #1 check("taken ie on", {cmp_irq_req, cmp_trigger}, 32'h0);
    drive_pos(0, 16'h0);
    drive_pos(0, 16'h03E8);
    wr(`CMX_OFS_STATUS, 32'h80);
    rdchk("write zero keeps", `CMX_OFS_STATUS, 32'h90, 32'h90);
    count_samples(3'h2);
    wr(`CMX_OFS_STATUS, 32'h90);
    rdchk("write one clears", `CMX_OFS_STATUS, 32'h90, 32'h80);
    wr(`CMX_OFS_STATUS, 32'h0);
    count_samples(3'h4);
    finish_test();
  end
endmodule // cmx_top_tb
